// ---- pflc_pkg.sv ----
// constants for the synthesizer function and initialization latch control block
package pflc_pkg;

	// programming word
	localparam int WORD_W = 24;
	localparam int CTRL_LSB = 0;
	localparam logic [1:0] CTRL_R_LATCH = 2'h0;
	localparam logic [1:0] CTRL_N_LATCH = 2'h1;
	localparam logic [1:0] CTRL_FUNC_LATCH = 2'h2;
	localparam logic [1:0] CTRL_INIT_LATCH = 2'h3;

	// function / initialization latch fields
	localparam int FN_COUNTER_RESET = 2;
	localparam int FN_PD1 = 3;
	localparam int FN_MUX_LSB = 4;
	localparam int FN_CP_3STATE = 8;
	localparam int FN_FA_ENABLE = 9;
	localparam int FN_FA_MODE = 10;
	localparam int FN_TIMER_LSB = 11;
	localparam int FN_CUR1_LSB = 15;
	localparam int FN_CUR2_LSB = 18;
	localparam int FN_PD2 = 21;
	localparam int FN_PRESC_LSB = 22;
	localparam logic [WORD_W-1:0] FN_RESET_VALUE = 24'h000000;

	// R counter latch fields
	localparam int R_COUNT_LSB = 2;
	localparam int R_SYNC = 21;
	localparam int R_DELAY = 22;
	localparam logic [WORD_W-1:0] R_RESET_VALUE = 24'h000000;

	// N counter latch fields
	localparam int N_A_LSB = 2;
	localparam int N_B_LSB = 8;
	localparam int N_CP_GAIN = 21;
	localparam logic [WORD_W-1:0] N_RESET_VALUE = 24'h000000;

	// field widths
	localparam int MUX_W = 3;
	localparam int TIMER_W = 4;
	localparam int CUR_W = 3;
	localparam int PRESC_W = 2;
	localparam int REF_W = 14;
	localparam int A_W = 6;
	localparam int B_W = 13;
	localparam int FA_CNT_W = 6;

	// fast acquire timeout: base plus step times code, in phase detector cycles
	localparam logic [FA_CNT_W-1:0] FA_TIMEOUT_BASE = 6'h03;
	localparam logic [FA_CNT_W-1:0] FA_TIMEOUT_STEP = 6'h04;

	// multiplexer output codes, bit 4 is the low bit of the field
	localparam logic [MUX_W-1:0] MUX_LOW = 3'h0;
	localparam logic [MUX_W-1:0] MUX_DIGITAL_LOCK = 3'h1;
	localparam logic [MUX_W-1:0] MUX_REF_DIV = 3'h2;
	localparam logic [MUX_W-1:0] MUX_N_DIV = 3'h3;
	localparam logic [MUX_W-1:0] MUX_HIGH = 3'h7;

	// pin input synchroniser lanes
	localparam int SYNC_W = 8;
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_LE = 2;
	localparam int PIN_HW_EN = 3;
	localparam int PIN_PD_CLK = 4;
	localparam int PIN_LOCK = 5;
	localparam int PIN_REF_DIV = 6;
	localparam int PIN_N_DIV = 7;

	typedef enum logic [1:0]
	{
		PFLC_RUN,
		PFLC_SYNC_WAIT,
		PFLC_DOWN
	} pflc_pd_state_e;

endpackage

// ---- pflc_sync.sv ----
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ns
module pflc_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// raw pins
	input wire logic [WIDTH-1:0] i_pin,
	// filtered level and rise pulse
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] level_next;
	logic [WIDTH-1:0] agree;

	// stage1 feeds stage2 only; the filter looks at stages two and three
	assign agree = ~(stage2_reg ^ stage3_reg);
	assign level_next = (agree & stage2_reg) | (~agree & o_level);

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			o_level <= '0;
			o_rise <= '0;
		end
		else
		begin
			stage1_reg <= i_pin;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			o_level <= level_next;
			o_rise <= level_next & ~o_level;
		end
	end
endmodule

// ---- pflc_top.sv ----
// serial-programmed function and initialization latch control for an integer-N synthesizer
//
// Overview of operation
// - counter reset bit set holds R, A and B counters in reset until cleared.
// - hardware enable low forces power down, overriding software power-down bits.
// - power down tristates charge pump; serial programming keeps working.
// - enable high and power_down_bit_1 at 0 gives normal operation.
// - power-down bits (0,1) power down as soon as the word is taken.
// - power-down bits (1,1) power down on the next charge-pump cycle.
// - multiplexer field picks the mux_output_pin source; code 1 gives digital lock.
// - charge-pump three-state bit at 1 puts charge pump in high impedance.
// - fast acquire enable bit allows fast acquire; 0 disables it entirely.
// - mode-select bit picks fast acquire mode 1 at 0, mode 2 at 1.
// - fast acquire entered only when N-latch gain bit is 1 and enabled.
// - mode 1 leaves fast acquire when host writes the gain bit to 0.
// - mode 2 leaves on timeout and clears the gain bit itself.
// - mode 2 timeout is 3 plus 4 times timer code phase_detector cycles.
// - two independent 3-bit charge-pump current fields, settings 1 and 2.
// - 2-bit prescaler field selects one of four dual-modulus ratios.
// - control bits (1,1) select initialization latch, same layout as function latch.
// - initialization latch write gives one counter reset pulse; N writes do not.
// - initialization pulse also gates entry into synchronous power down.
// - counter reset tristates charge pump without triggering synchronous power down.
// - R-latch resync bit resynchronizes prescaler, delayed when resync_delay_bit set.
// - control bits (0,0) select R latch with reference count and resync bits.
// - N-latch bit 21 is the charge-pump gain bit steering fast acquire.
`timescale 1ns/1ns
module pflc_top (
	// system clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	// three-wire serial port
	input wire logic I_SER_CLK,
	input wire logic I_SER_DATA,
	input wire logic I_SER_LATCH_EN,
	// hardware enable and loop signals
	input wire logic I_HW_ENABLE,
	input wire logic I_PHASE_DETECTOR_CLK,
	input wire logic I_DIGITAL_LOCK,
	input wire logic I_REF_DIV_OUT,
	input wire logic I_N_DIV_OUT,
	// counter controls
	output logic O_COUNTER_RESET,
	output logic [pflc_pkg::REF_W-1:0] O_REF_COUNT,
	output logic [pflc_pkg::A_W-1:0] O_A_COUNT,
	output logic [pflc_pkg::B_W-1:0] O_B_COUNT,
	output logic [pflc_pkg::PRESC_W-1:0] O_PRESCALER_SEL,
	output logic O_RESYNC_EN,
	output logic O_RESYNC_DELAY,
	// charge pump and power
	output logic O_POWER_DOWN,
	output logic O_CP_TRISTATE,
	output logic [pflc_pkg::CUR_W-1:0] O_CP_CURRENT_1,
	output logic [pflc_pkg::CUR_W-1:0] O_CP_CURRENT_2,
	output logic O_CP_CURRENT_SEL_2,
	output logic O_FAST_ACQUIRE,
	output logic O_CP_GAIN,
	// multiplexer output
	output logic O_MUX_OUTPUT_PIN
);
	import pflc_pkg::*;

	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_level;
	logic [SYNC_W-1:0] pin_rise;

	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] func_reg;
	logic [WORD_W-1:0] rlatch_reg;
	logic [WORD_W-1:0] nlatch_reg;
	logic cp_gain_reg;
	logic init_pulse_reg;
	pflc_pd_state_e pd_state_reg;
	pflc_pd_state_e pd_state_next;
	logic fa_active_reg;
	logic [FA_CNT_W-1:0] fa_cnt_reg;
	logic [FA_CNT_W-1:0] fa_cnt_next;

	// timeout in phase detector cycles for a timer code
	function automatic logic [FA_CNT_W-1:0] fa_timeout(input logic [TIMER_W-1:0] code);
		logic [FA_CNT_W-1:0] wide;
		wide = {{(FA_CNT_W-TIMER_W){1'b0}}, code};
		fa_timeout = FA_TIMEOUT_BASE + FA_TIMEOUT_STEP * wide;
	endfunction

	assign pin_raw[PIN_SCLK] = I_SER_CLK;
	assign pin_raw[PIN_SDATA] = I_SER_DATA;
	assign pin_raw[PIN_LE] = I_SER_LATCH_EN;
	assign pin_raw[PIN_HW_EN] = I_HW_ENABLE;
	assign pin_raw[PIN_PD_CLK] = I_PHASE_DETECTOR_CLK;
	assign pin_raw[PIN_LOCK] = I_DIGITAL_LOCK;
	assign pin_raw[PIN_REF_DIV] = I_REF_DIV_OUT;
	assign pin_raw[PIN_N_DIV] = I_N_DIV_OUT;

	pflc_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_pin(pin_raw),
		.o_level(pin_level),
		.o_rise(pin_rise)
	);

	// serial port decode
	wire ser_shift = pin_rise[PIN_SCLK];
	wire word_take = pin_rise[PIN_LE];
	wire [1:0] word_ctrl = shift_reg[CTRL_LSB+1:CTRL_LSB];
	wire wr_r = word_take && (word_ctrl == CTRL_R_LATCH);
	wire wr_n = word_take && (word_ctrl == CTRL_N_LATCH);
	wire wr_init = word_take && (word_ctrl == CTRL_INIT_LATCH);
	wire wr_func = word_take && ((word_ctrl == CTRL_FUNC_LATCH) || wr_init);
	wire pd_tick = pin_rise[PIN_PD_CLK];
	wire hw_enable = pin_level[PIN_HW_EN];

	// function latch fields
	wire f_counter_reset = func_reg[FN_COUNTER_RESET];
	wire f_pd1 = func_reg[FN_PD1];
	wire f_pd2 = func_reg[FN_PD2];
	wire [MUX_W-1:0] f_mux = func_reg[FN_MUX_LSB+MUX_W-1:FN_MUX_LSB];
	wire f_cp_3state = func_reg[FN_CP_3STATE];
	wire f_fa_enable = func_reg[FN_FA_ENABLE];
	wire f_fa_mode2 = func_reg[FN_FA_MODE];
	wire [TIMER_W-1:0] f_timer = func_reg[FN_TIMER_LSB+TIMER_W-1:FN_TIMER_LSB];

	// fast acquire control
	wire fa_request = cp_gain_reg && f_fa_enable;
	wire fa_count_done = fa_active_reg && f_fa_mode2 && pd_tick && (fa_cnt_reg <= 6'h01);
	wire fa_timeout_hit = fa_count_done && !wr_n;
	wire fa_active_next = fa_request && !fa_timeout_hit;

	always_comb
	begin
		fa_cnt_next = fa_cnt_reg;
		if (fa_request && !fa_active_reg)
		begin
			fa_cnt_next = fa_timeout(f_timer);
		end
		else if (fa_active_reg && f_fa_mode2 && pd_tick && (fa_cnt_reg != 6'h00))
		begin
			fa_cnt_next = fa_cnt_reg - 6'h01;
		end
	end

	// software power down; hardware enable sampled through the pin filter
	always_comb
	begin
		pd_state_next = pd_state_reg;
		if (!hw_enable)
		begin
			pd_state_next = PFLC_DOWN;
		end
		else if (!f_pd1)
		begin
			pd_state_next = PFLC_RUN;
		end
		else if (!f_pd2)
		begin
			pd_state_next = PFLC_DOWN;
		end
		else
		begin
			case (pd_state_reg)
				PFLC_RUN, PFLC_SYNC_WAIT:
				begin
					// wait for a charge-pump cycle or the init pulse
					if (pd_tick || init_pulse_reg)
					begin
						pd_state_next = PFLC_DOWN;
					end
					else
					begin
						pd_state_next = PFLC_SYNC_WAIT;
					end
				end
				PFLC_DOWN:
				begin
					pd_state_next = PFLC_DOWN;
				end
				default:
				begin
					pd_state_next = PFLC_DOWN;
				end
			endcase
		end
	end

	// multiplexer source select
	logic mux_next;
	always_comb
	begin
		case (f_mux)
			MUX_DIGITAL_LOCK: mux_next = pin_level[PIN_LOCK];
			MUX_REF_DIV: mux_next = pin_level[PIN_REF_DIV];
			MUX_N_DIV: mux_next = pin_level[PIN_N_DIV];
			MUX_HIGH: mux_next = 1'b1;
			default: mux_next = 1'b0;
		endcase
	end

	wire pd_next = (pd_state_next == PFLC_DOWN);
	// the counter reset bit never reaches the power-down state machine; the init pulse does
	wire cnt_reset_next = f_counter_reset || init_pulse_reg;
	wire tristate_next = f_cp_3state || pd_next || f_counter_reset;

	// shift register and latches; shifting continues in power down
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			shift_reg <= '0;
		end
		else if (ser_shift)
		begin
			shift_reg <= {shift_reg[WORD_W-2:0], pin_level[PIN_SDATA]};
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			func_reg <= FN_RESET_VALUE;
			rlatch_reg <= R_RESET_VALUE;
			nlatch_reg <= N_RESET_VALUE;
		end
		else
		begin
			if (wr_func)
			begin
				func_reg <= shift_reg;
			end
			if (wr_r)
			begin
				rlatch_reg <= shift_reg;
			end
			if (wr_n)
			begin
				nlatch_reg <= shift_reg;
			end
		end
	end

	// a host write of the gain bit wins over a same-cycle timeout clear
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			cp_gain_reg <= 1'b0;
		end
		else if (wr_n)
		begin
			cp_gain_reg <= shift_reg[N_CP_GAIN];
		end
		else if (fa_timeout_hit)
		begin
			cp_gain_reg <= 1'b0;
		end
	end

	// one pulse per initialization write only
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			init_pulse_reg <= 1'b0;
		end
		else
		begin
			init_pulse_reg <= wr_init;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			pd_state_reg <= PFLC_RUN;
			fa_active_reg <= 1'b0;
			fa_cnt_reg <= '0;
		end
		else
		begin
			pd_state_reg <= pd_state_next;
			fa_active_reg <= fa_active_next;
			fa_cnt_reg <= fa_cnt_next;
		end
	end

	// registered outputs
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			O_COUNTER_RESET <= 1'b0;
			O_POWER_DOWN <= 1'b0;
			O_CP_TRISTATE <= 1'b0;
			O_FAST_ACQUIRE <= 1'b0;
			O_CP_GAIN <= 1'b0;
			O_MUX_OUTPUT_PIN <= 1'b0;
		end
		else
		begin
			O_COUNTER_RESET <= cnt_reset_next;
			O_POWER_DOWN <= pd_next;
			O_CP_TRISTATE <= tristate_next;
			O_FAST_ACQUIRE <= fa_active_next;
			O_CP_GAIN <= cp_gain_reg;
			O_MUX_OUTPUT_PIN <= mux_next;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_B)
		begin
			O_REF_COUNT <= '0;
			O_A_COUNT <= '0;
			O_B_COUNT <= '0;
			O_PRESCALER_SEL <= '0;
			O_RESYNC_EN <= 1'b0;
			O_RESYNC_DELAY <= 1'b0;
			O_CP_CURRENT_1 <= '0;
			O_CP_CURRENT_2 <= '0;
			O_CP_CURRENT_SEL_2 <= 1'b0;
		end
		else
		begin
			O_REF_COUNT <= rlatch_reg[R_COUNT_LSB+REF_W-1:R_COUNT_LSB];
			O_A_COUNT <= nlatch_reg[N_A_LSB+A_W-1:N_A_LSB];
			O_B_COUNT <= nlatch_reg[N_B_LSB+B_W-1:N_B_LSB];
			O_PRESCALER_SEL <= func_reg[FN_PRESC_LSB+PRESC_W-1:FN_PRESC_LSB];
			O_RESYNC_EN <= rlatch_reg[R_SYNC];
			// delay only matters while resync is on
			O_RESYNC_DELAY <= rlatch_reg[R_SYNC] && rlatch_reg[R_DELAY];
			O_CP_CURRENT_1 <= func_reg[FN_CUR1_LSB+CUR_W-1:FN_CUR1_LSB];
			O_CP_CURRENT_2 <= func_reg[FN_CUR2_LSB+CUR_W-1:FN_CUR2_LSB];
			// setting 2 drives the pump during fast acquire
			O_CP_CURRENT_SEL_2 <= fa_active_next;
		end
	end
endmodule

// ---- pflc_asserts.sv ----
// port assertions for the latch control block
`timescale 1ns/1ns
module pflc_asserts (
	// clock, reset and pins
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	input wire logic I_SER_LATCH_EN,
	input wire logic I_HW_ENABLE,
	input wire logic I_PHASE_DETECTOR_CLK,
	// outputs
	input wire logic [pflc_pkg::REF_W-1:0] O_REF_COUNT,
	input wire logic [pflc_pkg::B_W-1:0] O_B_COUNT,
	input wire logic O_RESYNC_EN,
	input wire logic O_RESYNC_DELAY,
	input wire logic O_POWER_DOWN,
	input wire logic O_CP_TRISTATE,
	input wire logic O_CP_CURRENT_SEL_2,
	input wire logic O_FAST_ACQUIRE,
	input wire logic O_CP_GAIN
);
	import pflc_pkg::*;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RST_B);
	// eight quiet cycles outlast the pin filter and output registers
	sequence s_quiet;
		(!I_SER_LATCH_EN) [*8];
	endsequence
	sequence s_idle;
		(I_HW_ENABLE && !I_SER_LATCH_EN && !I_PHASE_DETECTOR_CLK) [*8];
	endsequence
	a_down_tristate: assert property (O_POWER_DOWN |-> O_CP_TRISTATE)
		else $error("charge pump driven in power down");
	a_hw_down: assert property ($fell(I_HW_ENABLE) ##0 (!I_HW_ENABLE) [*8] |-> O_POWER_DOWN)
		else $error("enable low did not power down");
	a_resync_pair: assert property (O_RESYNC_DELAY |-> O_RESYNC_EN)
		else $error("delay without resync");
	a_latch_hold: assert property (s_quiet |=> $stable({O_REF_COUNT, O_B_COUNT}))
		else $error("latch output moved without a write");
	a_fast_gain: assert property (O_FAST_ACQUIRE |-> O_CP_GAIN)
		else $error("fast acquire without gain bit");
	a_sel2_fast: assert property (O_CP_CURRENT_SEL_2 == O_FAST_ACQUIRE)
		else $error("current select differs from fast acquire");
	a_timeout_clear: assert property (s_quiet ##0 $fell(O_FAST_ACQUIRE) |-> ##1 !O_CP_GAIN)
		else $error("timeout left gain bit set");
	a_sync_wait: assert property (s_idle |=> !$rose(O_POWER_DOWN))
		else $error("power down without a cause");
endmodule
bind pflc_top pflc_asserts i_pflc_asserts (.I_SYS_CLK, .I_RST_B, .I_SER_LATCH_EN, .I_HW_ENABLE,
	.I_PHASE_DETECTOR_CLK, .O_REF_COUNT, .O_B_COUNT, .O_RESYNC_EN, .O_RESYNC_DELAY,
	.O_POWER_DOWN, .O_CP_TRISTATE, .O_CP_CURRENT_SEL_2, .O_FAST_ACQUIRE, .O_CP_GAIN);

// ---- pflc_host.sv ----
// host model driving the three-wire programming port
`timescale 1ns/1ns
module pflc_host (
	// serial pins
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_ser_latch_en
);
	initial
	begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b1;
		o_ser_latch_en = 1'b0;
	end
	// clock still between frames; data flipped once its hold is over
	task automatic send(input logic [23:0] word);
		for (int b = 23; b >= 0; b--)
		begin
			o_ser_data = word[b];
			#62;
			o_ser_clk = 1'b1;
			#63;
			o_ser_clk = 1'b0;
		end
		#62;
		o_ser_data = ~o_ser_data;
		#63;
		o_ser_latch_en = 1'b1;
		#125;
		o_ser_latch_en = 1'b0;
		#125;
	endtask
endmodule

// ---- tb_pflc_top.sv ----
// self-checking bench for the latch control block
`timescale 1ns/1ns
module tb_pflc_top;
	import pflc_pkg::*;
	logic I_SYS_CLK, I_RST_B, I_HW_ENABLE, I_PHASE_DETECTOR_CLK;
	logic I_DIGITAL_LOCK, I_REF_DIV_OUT, I_N_DIV_OUT;
	wire logic I_SER_CLK, I_SER_DATA, I_SER_LATCH_EN;
	logic O_COUNTER_RESET, O_RESYNC_EN, O_RESYNC_DELAY, O_POWER_DOWN, O_CP_TRISTATE;
	logic O_CP_CURRENT_SEL_2, O_FAST_ACQUIRE, O_CP_GAIN, O_MUX_OUTPUT_PIN;
	logic [REF_W-1:0] O_REF_COUNT;
	logic [A_W-1:0] O_A_COUNT;
	logic [B_W-1:0] O_B_COUNT;
	logic [PRESC_W-1:0] O_PRESCALER_SEL;
	logic [CUR_W-1:0] O_CP_CURRENT_1, O_CP_CURRENT_2;
	logic [23:0] fn = '0, r = '0, n = '0, w;
	logic pd = 1'b0, cr_prev;
	int fails = 0, checked = 0, pulses = 0, p;
	pflc_top i_pflc_top (.I_SYS_CLK, .I_RST_B, .I_SER_CLK, .I_SER_DATA, .I_SER_LATCH_EN,
		.I_HW_ENABLE, .I_PHASE_DETECTOR_CLK, .I_DIGITAL_LOCK, .I_REF_DIV_OUT, .I_N_DIV_OUT,
		.O_COUNTER_RESET, .O_REF_COUNT, .O_A_COUNT, .O_B_COUNT, .O_PRESCALER_SEL,
		.O_RESYNC_EN, .O_RESYNC_DELAY, .O_POWER_DOWN, .O_CP_TRISTATE, .O_CP_CURRENT_1,
		.O_CP_CURRENT_2, .O_CP_CURRENT_SEL_2, .O_FAST_ACQUIRE, .O_CP_GAIN, .O_MUX_OUTPUT_PIN);
	pflc_host i_pflc_host (.o_ser_clk(I_SER_CLK), .o_ser_data(I_SER_DATA),
		.o_ser_latch_en(I_SER_LATCH_EN));
	initial
	begin
		I_SYS_CLK = 1'b0;
		forever #4 I_SYS_CLK = ~I_SYS_CLK;
	end
	// count pulses mid-cycle, where the registered output has settled
	always @(negedge I_SYS_CLK)
	begin
		if (O_COUNTER_RESET === 1'b1 && cr_prev !== 1'b1)
			pulses++;
		cr_prev = O_COUNTER_RESET;
	end
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cmp_all;
		logic pdx, fa, mx;
		pdx = pd | ~I_HW_ENABLE;
		fa = n[21] & fn[9];
		mx = fn[6:4] == 3'h1 ? I_DIGITAL_LOCK : fn[6:4] == 3'h2 ? I_REF_DIV_OUT :
			fn[6:4] == 3'h3 ? I_N_DIV_OUT : fn[6:4] == 3'h7;
		chk("ref", 24'(O_REF_COUNT), 24'(r[15:2]));
		chk("sync", 24'({O_RESYNC_EN, O_RESYNC_DELAY}), 24'({r[21], r[22] & r[21]}));
		chk("ab", 24'({O_B_COUNT, O_A_COUNT}), 24'(n[20:2]));
		chk("presc", 24'(O_PRESCALER_SEL), 24'(fn[23:22]));
		chk("cur", 24'({O_CP_CURRENT_2, O_CP_CURRENT_1}), 24'(fn[20:15]));
		chk("crst", 24'(O_COUNTER_RESET), 24'(fn[2]));
		chk("pd", 24'({O_POWER_DOWN, O_CP_TRISTATE}), 24'({pdx, fn[8] | pdx | fn[2]}));
		chk("fast", 24'({O_FAST_ACQUIRE, O_CP_CURRENT_SEL_2, O_CP_GAIN}), 24'({fa, fa, n[21]}));
		chk("mux", 24'(O_MUX_OUTPUT_PIN), 24'(mx));
	endtask
	task automatic wr(input logic [23:0] word);
		i_pflc_host.send(word);
		if (word[1:0] == CTRL_R_LATCH)
			r = word;
		if (word[1:0] == CTRL_N_LATCH)
			n = word;
		if (word[1])
			fn = word;
		// init pulse stands in for the charge-pump cycle of synchronous power down
		if (word[1])
			pd = word[3] & (pd | ~word[21] | (word[1:0] == CTRL_INIT_LATCH));
		repeat (4) @(negedge I_SYS_CLK);
	endtask
	task automatic pulse_pd(input int cnt);
		repeat (cnt)
		begin
			I_PHASE_DETECTOR_CLK = 1'b1;
			repeat (4) @(negedge I_SYS_CLK);
			I_PHASE_DETECTOR_CLK = 1'b0;
			repeat (4) @(negedge I_SYS_CLK);
		end
		repeat (4) @(negedge I_SYS_CLK);
	endtask
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#400000;
		fails++;
		wrap_up;
	end
	initial
	begin
		{I_RST_B, I_HW_ENABLE, I_PHASE_DETECTOR_CLK} = 3'h2;
		{I_DIGITAL_LOCK, I_REF_DIV_OUT, I_N_DIV_OUT} = 3'h0;
		w = 24'($urandom(32'h6597));
		repeat (2) @(negedge I_SYS_CLK);
		I_RST_B = 1'b1;
		repeat (12) @(negedge I_SYS_CLK);
		cmp_all;
		for (int i = 0; i < 8; i++)
		begin
			w = 24'($urandom);
			wr({1'b0, w[22:2], CTRL_R_LATCH});
			wr({w[23:22], 1'b0, w[20:2], CTRL_N_LATCH});
			w = 24'($urandom);
			wr({w[23:22], 1'b0, w[20:10], 1'b0, w[8:7], i[2:0], 1'b0, ~i[0], CTRL_FUNC_LATCH});
			{I_DIGITAL_LOCK, I_REF_DIV_OUT, I_N_DIV_OUT} = 3'($urandom);
			repeat (10) @(negedge I_SYS_CLK);
			cmp_all;
		end
		p = pulses;
		wr(24'h828003);
		chk("ipulse", 24'(pulses), 24'(p + 1));
		wr(24'h00A0A5);
		chk("npulse", 24'(pulses), 24'(p + 1));
		cmp_all;
		wr(24'h00000A);
		cmp_all;
		w = 24'($urandom);
		wr({2'h0, w[21:2], CTRL_R_LATCH});
		cmp_all;
		I_HW_ENABLE = 1'b0;
		wr(24'h000002);
		cmp_all;
		I_HW_ENABLE = 1'b1;
		repeat (10) @(negedge I_SYS_CLK);
		cmp_all;
		wr(24'h001602);
		wr(24'h200001);
		cmp_all;
		pulse_pd(10);
		cmp_all;
		pulse_pd(1);
		n[21] = 1'b0;
		cmp_all;
		wr(24'h000202);
		wr(24'h200001);
		pulse_pd(20);
		cmp_all;
		wr(24'h000001);
		cmp_all;
		wr(24'h000002);
		wr(24'h200001);
		cmp_all;
		wr(24'h20000A);
		cmp_all;
		pulse_pd(1);
		pd = 1'b1;
		cmp_all;
		wr(24'h000006);
		cmp_all;
		wr(24'h000C80);
		wr(24'h001211);
		cmp_all;
		wr(24'h000002);
		cmp_all;
		wr(24'h20000B);
		cmp_all;
		wrap_up;
	end
endmodule
